// ==== rtl/fsd_top.v ====
// Purpose: fan speed measurement and drive coordination
// Assumes: AXI4-Lite slave, one clock, low-active thermal pin
// Notes: registers are 8 bits except the 16-bit speed readings
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`include "fsd_consts.vh"

// Functional notes
// - manual mode: thermal forces only with override
// - thermal level: full duty or programmed maximum
// - thermal disable bit blocks thermal forcing
// - low frequency choices plus one high
// - four sense inputs, three drive outputs
// - default: sense tied to own drive, four to three
// - grouping bit ties sense two-four to three
// - high frequency mode needs no synchronisation
// - count 90 kHz reference over N periods
// - N per fan from two-bit field
// - codes 00..11 mean one to four
// - stall or too slow reads all ones
// - refresh each second, or 250 ms fast
module fsd_top
#(
	parameter UPD_CYC = `FSD_UPD_CYC,
	parameter FAST_CYC = `FSD_FAST_CYC,
	parameter HF_DIV = 9,
	parameter LF_DIV = 20
)
(
	// clock and reset
	input wire clock_i,
	input wire rst_i,
	// axi write address
	input wire s_axi_awvalid_i,
	output wire s_axi_awready_o,
	input wire [9:0] s_axi_awaddr_i,
	input wire [2:0] s_axi_awprot_i,
	// axi write data
	input wire s_axi_wvalid_i,
	output wire s_axi_wready_o,
	input wire [31:0] s_axi_wdata_i,
	input wire [3:0] s_axi_wstrb_i,
	// axi write response
	output reg s_axi_bvalid_o,
	input wire s_axi_bready_i,
	output reg [1:0] s_axi_bresp_o,
	// axi read address
	input wire s_axi_arvalid_i,
	output wire s_axi_arready_o,
	input wire [9:0] s_axi_araddr_i,
	input wire [2:0] s_axi_arprot_i,
	// axi read data
	output reg s_axi_rvalid_o,
	input wire s_axi_rready_i,
	output reg [31:0] s_axi_rdata_o,
	output reg [1:0] s_axi_rresp_o,
	// fan pins
	input wire thermal_event_line_n_i,
	input wire speed_sense_one_i,
	input wire speed_sense_two_i,
	input wire speed_sense_three_i,
	input wire speed_sense_four_i,
	output wire fan_drive_one_o,
	output wire fan_drive_two_o,
	output wire fan_drive_three_o
);
	localparam integer REF_DIV = `FSD_REF_DIV;
	localparam [25:0] UPD_LIM = UPD_CYC[25:0] - 26'h0000001;
	localparam [25:0] FAST_LIM = FAST_CYC[25:0] - 26'h0000001;
	localparam [9:0] REF_LIM = REF_DIV[9:0] - 10'h001;

	reg [4:0] pin_s1_reg;
	reg [4:0] pin_s2_reg;
	reg [7:0] acoust_reg;
	reg [7:0] ppr_reg;
	reg [7:0] cfg4_reg;
	reg [7:0] cfg6_reg;
	reg [7:0] ctrl_reg;
	reg [7:0] maxd_reg;
	reg [7:0] duty_reg [0:2];
	reg aw_ok_reg;
	reg w_ok_reg;
	reg [7:0] aw_idx_reg;
	reg [7:0] wdata_reg;
	reg wlane_reg;
	reg [9:0] ref_cnt_reg;
	reg ref_tick_reg;
	reg [25:0] upd_cnt_reg;
	reg upd_tick_reg;
	reg [31:0] rd_word;
	wire [15:0] tach_cnt [0:3];
	wire [2:0] drive;
	wire [3:0] gate;
	wire [3:0] sense;
	wire thermal_event_line_on;
	wire force_on;
	wire [7:0] force_duty;
	wire [7:0] ar_idx;
	wire hf_mode;
	integer i;

	// writable control registers
	function wr_map;
		input [7:0] idx;
		begin
			wr_map = (idx == `FSD_IDX_ACOUST) || (idx == `FSD_IDX_PPR) ||
				(idx == `FSD_IDX_CFG4) || (idx == `FSD_IDX_CFG6) ||
				(idx == `FSD_IDX_CTRL) || (idx == `FSD_IDX_MAXD) ||
				(idx >= `FSD_IDX_DUTY0 && idx <= `FSD_IDX_DUTY0 + 8'h02);
		end
	endfunction

	// read-only speed readings at even indices
	function tach_map;
		input [7:0] idx;
		begin
			tach_map = ((idx >> 3) == (`FSD_IDX_TACH0 >> 3)) && !idx[0];
		end
	endfunction

	// pins are asynchronous to the clock
	always @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			pin_s1_reg <= 5'h1F;
			pin_s2_reg <= 5'h1F;
		end
		else
		begin
			pin_s1_reg <= {thermal_event_line_n_i, speed_sense_four_i,
				speed_sense_three_i, speed_sense_two_i, speed_sense_one_i};
			pin_s2_reg <= pin_s1_reg;
		end
	end

	assign sense = pin_s2_reg[3:0];
	assign thermal_event_line_on = ~pin_s2_reg[4];
	assign hf_mode = ctrl_reg[`FSD_BIT_HF];

	// write channel: address and data accepted in either order
	assign s_axi_awready_o = !aw_ok_reg && !s_axi_bvalid_o;
	assign s_axi_wready_o = !w_ok_reg && !s_axi_bvalid_o;

	always @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			aw_ok_reg <= 1'b0;
			w_ok_reg <= 1'b0;
			aw_idx_reg <= 8'h00;
			wdata_reg <= 8'h00;
			wlane_reg <= 1'b0;
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o <= `FSD_RESP_OKAY;
			acoust_reg <= `FSD_RST_ZERO;
			ppr_reg <= `FSD_RST_PPR;
			cfg4_reg <= `FSD_RST_ZERO;
			cfg6_reg <= `FSD_RST_ZERO;
			ctrl_reg <= `FSD_RST_ZERO;
			maxd_reg <= `FSD_FULL_DUTY;
			for (i = 0; i < 3; i = i + 1)
				duty_reg[i] <= `FSD_RST_ZERO;
		end
		else
		begin
			if (s_axi_awvalid_i && s_axi_awready_o)
			begin
				aw_ok_reg <= 1'b1;
				aw_idx_reg <= s_axi_awaddr_i[9:2];
			end
			if (s_axi_wvalid_i && s_axi_wready_o)
			begin
				w_ok_reg <= 1'b1;
				wdata_reg <= s_axi_wdata_i[7:0];
				wlane_reg <= s_axi_wstrb_i[0];
			end
			if (aw_ok_reg && w_ok_reg)
			begin
				aw_ok_reg <= 1'b0;
				w_ok_reg <= 1'b0;
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o <= wr_map(aw_idx_reg) ? `FSD_RESP_OKAY :
					`FSD_RESP_SLVERR;
				if (wlane_reg)
				begin
					case (aw_idx_reg)
					`FSD_IDX_ACOUST: acoust_reg <= wdata_reg;
					`FSD_IDX_PPR: ppr_reg <= wdata_reg;
					`FSD_IDX_CFG4: cfg4_reg <= wdata_reg;
					`FSD_IDX_CFG6: cfg6_reg <= wdata_reg;
					`FSD_IDX_CTRL: ctrl_reg <= wdata_reg;
					`FSD_IDX_MAXD: maxd_reg <= wdata_reg;
					`FSD_IDX_DUTY0: duty_reg[0] <= wdata_reg;
					`FSD_IDX_DUTY0 + 8'h01: duty_reg[1] <= wdata_reg;
					`FSD_IDX_DUTY0 + 8'h02: duty_reg[2] <= wdata_reg;
					default: ctrl_reg <= ctrl_reg;
					endcase
				end
			end
			else if (s_axi_bvalid_o && s_axi_bready_i)
				s_axi_bvalid_o <= 1'b0;
		end
	end

	// read mux
	assign ar_idx = s_axi_araddr_i[9:2];
	assign s_axi_arready_o = !s_axi_rvalid_o;

	always @*
	begin
		rd_word = 32'h00000000;
		case (ar_idx)
		`FSD_IDX_ACOUST: rd_word[7:0] = acoust_reg;
		`FSD_IDX_PPR: rd_word[7:0] = ppr_reg;
		`FSD_IDX_CFG4: rd_word[7:0] = cfg4_reg;
		`FSD_IDX_CFG6: rd_word[7:0] = cfg6_reg;
		`FSD_IDX_CTRL: rd_word[7:0] = ctrl_reg;
		`FSD_IDX_MAXD: rd_word[7:0] = maxd_reg;
		`FSD_IDX_DUTY0: rd_word[7:0] = duty_reg[0];
		`FSD_IDX_DUTY0 + 8'h01: rd_word[7:0] = duty_reg[1];
		`FSD_IDX_DUTY0 + 8'h02: rd_word[7:0] = duty_reg[2];
		default:
		begin
			if (tach_map(ar_idx))
				rd_word[15:0] = tach_cnt[ar_idx[2:1]];
		end
		endcase
	end

	always @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o <= 32'h00000000;
			s_axi_rresp_o <= `FSD_RESP_OKAY;
		end
		else if (s_axi_arvalid_i && s_axi_arready_o)
		begin
			s_axi_rvalid_o <= 1'b1;
			s_axi_rdata_o <= rd_word;
			s_axi_rresp_o <= (wr_map(ar_idx) || tach_map(ar_idx)) ?
				`FSD_RESP_OKAY : `FSD_RESP_DECERR;
		end
		else if (s_axi_rready_i)
			s_axi_rvalid_o <= 1'b0;
	end

	// reference and refresh pulses
	always @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			ref_cnt_reg <= 10'h000;
			ref_tick_reg <= 1'b0;
			upd_cnt_reg <= 26'h0000000;
			upd_tick_reg <= 1'b0;
		end
		else
		begin
			ref_tick_reg <= (ref_cnt_reg == REF_LIM);
			if (ref_cnt_reg == REF_LIM)
				ref_cnt_reg <= 10'h000;
			else
				ref_cnt_reg <= ref_cnt_reg + 10'h001;
			if (upd_cnt_reg >= (ctrl_reg[`FSD_BIT_FAST] ? FAST_LIM : UPD_LIM))
			begin
				upd_cnt_reg <= 26'h0000000;
				upd_tick_reg <= 1'b1;
			end
			else
			begin
				upd_cnt_reg <= upd_cnt_reg + 26'h0000001;
				upd_tick_reg <= 1'b0;
			end
		end
	end

	// manual mode needs the override bit
	assign force_on = thermal_event_line_on && !cfg4_reg[`FSD_BIT_THDIS] &&
		(!ctrl_reg[`FSD_BIT_MAN] || cfg6_reg[`FSD_BIT_OVR]);
	assign force_duty = cfg4_reg[`FSD_BIT_THMAX] ? maxd_reg :
		`FSD_FULL_DUTY;

	// three drives for four sense inputs
	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1)
		begin : gen_drv
			fsd_pwm_gen
			#(
				.HF_DIV(HF_DIV),
				.LF_DIV(LF_DIV)
			)
			u_pwm
			(
				.clock_i(clock_i),
				.rst_i(rst_i),
				.hf_i(hf_mode),
				.lfsel_i(ctrl_reg[`FSD_LFSEL_LSB +: 3]),
				.duty_i(force_on ? force_duty : duty_reg[g]),
				.drive_o(drive[g])
			);
		end
	endgenerate

	assign fan_drive_one_o = drive[0];
	assign fan_drive_two_o = drive[1];
	assign fan_drive_three_o = drive[2];

	// own drive; three and four on third
	// grouping moves sense two to third drive
	assign gate[0] = hf_mode | drive[0];
	assign gate[1] = hf_mode |
		(acoust_reg[`FSD_BIT_SYNC] ? drive[2] : drive[1]);
	assign gate[2] = hf_mode | drive[2];
	assign gate[3] = hf_mode | drive[2];

	generate
		for (g = 0; g < 4; g = g + 1)
		begin : gen_tach
			fsd_tach_meas u_meas
			(
				.clock_i(clock_i),
				.rst_i(rst_i),
				.ref_tick_i(ref_tick_reg),
				.upd_tick_i(upd_tick_reg),
				.sense_i(sense[g]),
				.gate_i(gate[g]),
				.ppr_i(ppr_reg[2 * g +: 2]),
				.count_o(tach_cnt[g])
			);
		end
	endgenerate
endmodule // fsd_top

// ==== rtl/fsd_consts.vh ====
// Purpose: shared constants for the fan speed measure and drive block
// Assumes: register indices; byte address is four times the index
// Notes: timing counts derive from the 50 MHz system clock
`ifndef FSD_CONSTS_VH
`define FSD_CONSTS_VH
`define FSD_IDX_CFG6 8'h10
`define FSD_IDX_TACH0 8'h28
`define FSD_IDX_DUTY0 8'h30
`define FSD_IDX_MAXD 8'h38
`define FSD_IDX_CTRL 8'h40
`define FSD_IDX_ACOUST 8'h62
`define FSD_IDX_PPR 8'h7B
`define FSD_IDX_CFG4 8'h7D
`define FSD_BIT_SYNC 4
`define FSD_BIT_OVR 3
`define FSD_BIT_THMAX 3
`define FSD_BIT_THDIS 2
`define FSD_BIT_MAN 0
`define FSD_BIT_HF 1
`define FSD_BIT_FAST 2
`define FSD_LFSEL_LSB 4
`define FSD_RST_PPR 8'h55
`define FSD_RST_ZERO 8'h00
`define FSD_FULL_DUTY 8'hFF
`define FSD_TACH_STALL 16'hFFFF
`define FSD_CLK_HZ 50000000
`define FSD_REF_HZ 90000
`define FSD_REF_DIV (`FSD_CLK_HZ / `FSD_REF_HZ)
`define FSD_UPD_MS 1000
`define FSD_FAST_MS 250
`define FSD_UPD_CYC (`FSD_CLK_HZ / 1000 * `FSD_UPD_MS)
`define FSD_FAST_CYC (`FSD_CLK_HZ / 1000 * `FSD_FAST_MS)
`define FSD_RESP_OKAY 2'b00
`define FSD_RESP_SLVERR 2'b10
`define FSD_RESP_DECERR 2'b11
`endif

// ==== rtl/fsd_tach_meas.v ====
// Purpose: period measurement of one speed-sense input
// Assumes: sense_i already synchronised; ticks are one-cycle pulses
// Notes: count is in reference periods over N sense periods
module fsd_tach_meas
(
	// clock and reset
	input wire clock_i,
	input wire rst_i,
	// timing pulses
	input wire ref_tick_i,
	input wire upd_tick_i,
	// sense and setup
	input wire sense_i,
	input wire gate_i,
	input wire [1:0] ppr_i,
	// result
	output reg [15:0] count_o
);
	localparam ST_IDLE = 2'd0;
	localparam ST_WAIT = 2'd1;
	localparam ST_COUNT = 2'd2;

	reg [1:0] state_reg;
	reg prev_reg;
	reg [15:0] cnt_reg;
	reg [1:0] edge_reg;
	wire rise;

	// edges seen while gate_i is low are ignored on purpose
	assign rise = sense_i & ~prev_reg & gate_i;

	always @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state_reg <= ST_IDLE;
			// idle level of a pulled-up line, no false edge
			prev_reg <= 1'b1;
			cnt_reg <= 16'h0000;
			edge_reg <= 2'b00;
			count_o <= 16'h0000;
		end
		else
		begin
			prev_reg <= sense_i;
			if (upd_tick_i)
			begin
				if (state_reg != ST_IDLE)
					count_o <= `FSD_TACH_STALL;
				state_reg <= ST_WAIT;
			end
			else
			begin
				case (state_reg)
				ST_WAIT:
				begin
					if (rise)
					begin
						cnt_reg <= 16'h0000;
						edge_reg <= 2'b00;
						state_reg <= ST_COUNT;
					end
				end
				ST_COUNT:
				begin
					if (ref_tick_i && cnt_reg != `FSD_TACH_STALL)
						cnt_reg <= cnt_reg + 16'h0001;
					if (rise)
					begin
						if (edge_reg == ppr_i)
						begin
							count_o <= cnt_reg;
							state_reg <= ST_IDLE;
						end
						else
							edge_reg <= edge_reg + 2'b01;
					end
				end
				ST_IDLE:
					state_reg <= ST_IDLE;
				default:
					state_reg <= ST_IDLE;
				endcase
			end
		end
	end
endmodule // fsd_tach_meas

// ==== rtl/fsd_pwm_gen.v ====
// Purpose: one fan drive output with selectable frequency
// Assumes: duty_i is already resolved against thermal overrides
// Notes: full duty drives a steady high level
module fsd_pwm_gen
#(
	parameter HF_DIV = 9,
	parameter LF_DIV = 20
)
(
	// clock and reset
	input wire clock_i,
	input wire rst_i,
	// setup
	input wire hf_i,
	input wire [2:0] lfsel_i,
	input wire [7:0] duty_i,
	// drive
	output reg drive_o
);
	reg [15:0] pre_reg;
	reg [7:0] phase_reg;
	wire [15:0] limit;
	wire step;

	// several low rates, one high rate
	assign limit = hf_i ? (HF_DIV[15:0] - 16'h0001) :
		((LF_DIV[15:0] << lfsel_i) - 16'h0001);
	assign step = (pre_reg >= limit);

	always @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			pre_reg <= 16'h0000;
			phase_reg <= 8'h00;
			drive_o <= 1'b0;
		end
		else
		begin
			if (step)
			begin
				pre_reg <= 16'h0000;
				phase_reg <= phase_reg + 8'h01;
			end
			else
				pre_reg <= pre_reg + 16'h0001;
			drive_o <= (duty_i == `FSD_FULL_DUTY) | (phase_reg < duty_i);
		end
	end
endmodule // fsd_pwm_gen

// ==== sim/fsd_fan_model.sv ====
// Purpose: tach source standing in for one fan
// Assumes: open-collector tach output with a pull-up
// Notes: a stopped fan leaves the line pulled high
module fsd_fan_model
#(
	parameter int PERIOD = 1110
)
(
	// clock
	input wire logic clock_i,
	// control
	input wire logic spin_i,
	// tach
	output logic sense_o = 1'b1
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt = 0;
	always @(posedge clock_i)
	begin
		cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
		sense_o <= !spin_i || cnt >= PERIOD / 2;
	end
endmodule // fsd_fan_model

// ==== sim/fsd_top_asserts.sv ====
// Purpose: port-level checks for the fan speed block
// Assumes: one clock, reset active high
// Notes: register effects are judged by the bench
module fsd_top_asserts
(
	// clock and reset
	input wire clock_i,
	input wire rst_i,
	// write channels
	input wire s_axi_awvalid_i,
	input wire s_axi_awready_o,
	input wire s_axi_wvalid_i,
	input wire s_axi_wready_o,
	input wire s_axi_bvalid_o,
	input wire s_axi_bready_i,
	input wire [1:0] s_axi_bresp_o,
	// read channels
	input wire s_axi_arvalid_i,
	input wire s_axi_arready_o,
	input wire s_axi_rvalid_o,
	input wire s_axi_rready_i,
	input wire [31:0] s_axi_rdata_o,
	input wire [1:0] s_axi_rresp_o,
	// drive
	input wire fan_drive_one_o
);
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (rst_i);
	bvalid_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i
		|=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
		else $error("write response dropped");
	rvalid_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i
		|=> s_axi_rvalid_o && $stable({s_axi_rdata_o, s_axi_rresp_o}))
		else $error("read data dropped");
	read_answer_a: assert property (s_axi_arvalid_i && s_axi_arready_o
		|=> s_axi_rvalid_o)
		else $error("read answer late");
	rvalid_cause_a: assert property ($rose(s_axi_rvalid_o)
		|-> $past(s_axi_arvalid_i && s_axi_arready_o))
		else $error("read answer without request");
	write_block_a: assert property (s_axi_bvalid_o
		|-> !s_axi_awready_o && !s_axi_wready_o)
		else $error("write taken while answer pending");
	write_answer_a: assert property (s_axi_awvalid_i && s_axi_awready_o
		&& s_axi_wvalid_i && s_axi_wready_o |-> ##[1:3] s_axi_bvalid_o)
		else $error("write answer late");
	decerr_zero_a: assert property (s_axi_rvalid_o && s_axi_rresp_o == 2'h3
		|-> s_axi_rdata_o == 32'h00000000)
		else $error("decode error with data");
	reading_width_a: assert property (s_axi_rvalid_o
		|-> s_axi_rdata_o[31:16] == 16'h0000)
		else $error("upper read bits set");
	cover property (s_axi_rvalid_o && s_axi_rresp_o == 2'h3);
	cover property (s_axi_bvalid_o && s_axi_bresp_o == 2'h2);
	cover property ($rose(fan_drive_one_o));
endmodule // fsd_top_asserts

bind fsd_top fsd_top_asserts chk_i
(
	.clock_i, .rst_i, .s_axi_awvalid_i, .s_axi_awready_o,
	.s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bvalid_o, .s_axi_bready_i,
	.s_axi_bresp_o, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rvalid_o,
	.s_axi_rready_i, .s_axi_rdata_o, .s_axi_rresp_o, .fan_drive_one_o
);

// ==== sim/fsd_top_test.sv ====
// Purpose: self-checking bench for the fan speed block
// Assumes: tach sources run free at 1110 clocks a period
// Notes: short refresh counts keep the run brief
`include "fsd_consts.vh"
module fsd_top_test;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int UPD = 6000;
	typedef struct {logic [7:0] idx; int n;} fsd_row_t;
	fsd_row_t rows [4] = '{'{8'h28, 1}, '{8'h2A, 2}, '{8'h2C, 3}, '{8'h2E, 4}};
	logic clock_i = 1'b0;
	logic rst_i = 1'b1;
	logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0;
	logic s_axi_arvalid_i = 1'b0, s_axi_bready_i = 1'b1, s_axi_rready_i = 1'b1;
	logic [9:0] s_axi_awaddr_i = 10'h000, s_axi_araddr_i = 10'h000;
	logic [2:0] s_axi_awprot_i = 3'h0, s_axi_arprot_i = 3'h0;
	logic [31:0] s_axi_wdata_i = 32'h00000000;
	logic [3:0] s_axi_wstrb_i = 4'hF, spin = 4'hF;
	logic thermal_event_line_n_i = 1'b1;
	wire [3:0] sense;
	wire speed_sense_one_i = sense[0], speed_sense_two_i = sense[1];
	wire speed_sense_three_i = sense[2], speed_sense_four_i = sense[3];
	wire s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
	wire s_axi_arready_o, s_axi_rvalid_o;
	wire [1:0] s_axi_bresp_o, s_axi_rresp_o;
	wire [31:0] s_axi_rdata_o;
	wire fan_drive_one_o, fan_drive_two_o, fan_drive_three_o;
	int bad_count = 0, check_count = 0;
	logic [31:0] d;
	logic [1:0] r;
	fsd_top #(.UPD_CYC(UPD), .FAST_CYC(UPD / 4), .HF_DIV(3), .LF_DIV(2))
		uut (.*);
	for (genvar g = 0; g < 4; g++)
	begin : fan
		fsd_fan_model m (.clock_i(clock_i), .spin_i(spin[g]), .sense_o(sense[g]));
	end
	initial forever #10 clock_i = ~clock_i;

	task automatic chk(string nm, logic [31:0] lo, hi, g);
		check_count++;
		if (!((g >= lo) === 1'b1 && (g <= hi) === 1'b1))
		begin
			bad_count++;
			$display("[FAIL] %s expected %h..%h seen %h", nm, lo, hi, g);
		end
	endtask

	// bready stays high, so the answer is taken where it is seen
	task automatic wr(logic [7:0] a, logic [7:0] v, logic [1:0] e = 2'h0);
		int n = 0;
		s_axi_awaddr_i <= {a, 2'b00};
		s_axi_wdata_i <= {24'h000000, v};
		s_axi_awvalid_i <= 1'b1;
		s_axi_wvalid_i <= 1'b1;
		do
		begin
			@(posedge clock_i);
			n++;
			if (s_axi_awvalid_i && s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
			if (s_axi_wvalid_i && s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
		end
		while (s_axi_bvalid_o !== 1'b1 && n < 50);
		chk("bvalid", 1, 1, s_axi_bvalid_o);
		chk("bresp", e, e, s_axi_bresp_o);
	endtask

	task automatic rd(logic [7:0] a);
		int n = 0;
		s_axi_araddr_i <= {a, 2'b00};
		s_axi_arvalid_i <= 1'b1;
		do
		begin
			@(posedge clock_i);
			n++;
			if (s_axi_arvalid_i && s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
		end
		while (s_axi_rvalid_o !== 1'b1 && n < 50);
		chk("rvalid", 1, 1, s_axi_rvalid_o);
		d = s_axi_rdata_o;
		r = s_axi_rresp_o;
	endtask

	// thermal input passes a two-flop synchroniser first
	task automatic lvl(logic e);
		repeat (20) @(posedge clock_i);
		repeat (4)
		begin
			repeat (50) @(posedge clock_i);
			chk("drive_one", e, e, fan_drive_one_o);
			chk("drive_two", e, e, fan_drive_two_o);
			chk("drive_three", e, e, fan_drive_three_o);
		end
	endtask

	// two refresh periods so a full measurement has landed
	task automatic settle();
		repeat (2 * UPD + 500) @(posedge clock_i);
	endtask

	// first edge after a change may close a partial period
	task automatic per(logic [7:0] c, int p);
		realtime t;
		wr(`FSD_IDX_CTRL, c);
		repeat (2) @(posedge fan_drive_one_o);
		t = $realtime;
		@(posedge fan_drive_one_o);
		chk("period", p, p, int'(($realtime - t) / 20));
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial
	begin
		repeat (5) @(posedge clock_i);
		rst_i <= 1'b0;
		@(posedge clock_i);
		rd(`FSD_IDX_PPR);
		chk("ppr_reset", 8'h55, 8'h55, d);
		chk("ppr_resp", 2'h0, 2'h0, r);
		rd(8'hFF);
		chk("unmapped", 2'h3, 2'h3, r);
		wr(8'hFF, 8'h01, 2'h2);
		wr(`FSD_IDX_TACH0, 8'h01, 2'h2);
		wr(`FSD_IDX_CTRL, 8'h01);
		thermal_event_line_n_i <= 1'b0;
		lvl(1'b0);
		wr(`FSD_IDX_CFG6, 8'h08);
		lvl(1'b1);
		wr(`FSD_IDX_MAXD, 8'h00);
		wr(`FSD_IDX_CFG4, 8'h08);
		lvl(1'b0);
		wr(`FSD_IDX_CFG4, 8'h04);
		lvl(1'b0);
		thermal_event_line_n_i <= 1'b1;
		for (logic [7:0] a = 8'h30; a < 8'h33; a++) wr(a, 8'hFF);
		wr(`FSD_IDX_PPR, 8'hE4);
		settle();
		foreach (rows[i])
		begin
			rd(rows[i].idx);
			chk("speed", 2 * rows[i].n - 1, 2 * rows[i].n + 1, d);
		end
		spin[0] <= 1'b0;
		wr(8'h31, 8'h00);
		settle();
		rd(8'h28);
		chk("stalled", 32'h0000FFFF, 32'h0000FFFF, d);
		rd(8'h2A);
		chk("gated", 32'h0000FFFF, 32'h0000FFFF, d);
		wr(`FSD_IDX_ACOUST, 8'h10);
		settle();
		rd(8'h2A);
		chk("grouped", 3, 5, d);
		wr(8'h32, 8'h00);
		wr(`FSD_IDX_CTRL, 8'h02);
		settle();
		rd(8'h2E);
		chk("ungated", 7, 9, d);
		// fast refresh is too short for four periods
		wr(`FSD_IDX_CTRL, 8'h06);
		settle();
		rd(8'h2E);
		chk("fast", 32'h0000FFFF, 32'h0000FFFF, d);
		wr(`FSD_IDX_DUTY0, 8'h80);
		per(8'h01, 512);
		per(8'h11, 1024);
		per(8'h21, 2048);
		per(8'h03, 768);
		// reset in mid-run restores defaults
		rst_i <= 1'b1;
		repeat (5) @(posedge clock_i);
		chk("drive_reset", 0, 0,
			{fan_drive_one_o, fan_drive_two_o, fan_drive_three_o});
		rst_i <= 1'b0;
		@(posedge clock_i);
		rd(8'h2E);
		chk("tach_reset", 0, 0, d);
		rd(`FSD_IDX_PPR);
		chk("ppr_again", 8'h55, 8'h55, d);
		conclude();
	end

	initial
	begin
		repeat (95000) @(posedge clock_i);
		bad_count++;
		conclude();
	end
endmodule // fsd_top_test
